//--- core/wdtps_pkg.sv
// package for the watchdog timer with prescaler
// assumes one system clock domain; the watchdog oscillator arrives as a pin-level input
package wdtps_pkg;
	localparam int BASE_STAGES          = 8;
	localparam int BASE_DIV             = 256;
	localparam int PRE_BITS             = 7;
	localparam int INSN_DIV             = 4;
	localparam int INSN_DIV_BITS        = 2;
	localparam int SEL_LSB              = 0;
	localparam int SEL_MSB              = 2;
	localparam logic [7:0] SELECT_RESET = 8'h07;
	localparam logic [1:0] INSN_LAST    = 2'h3;

	typedef struct packed {
		logic enable;
		logic use_osc;
		logic osc_enable;
		logic paired_clear;
	} wdtps_option_type;

	typedef struct packed {
		logic clear_single;
		logic clear_first;
		logic clear_second;
		logic halt;
	} wdtps_insn_type;

	typedef struct packed {
		logic timeout;
		logic powerdown;
	} wdtps_status_type;
endpackage

//--- core/wdtps_core.sv
// watchdog counter with base divider, prescaler, clear logic and status flags
// assumes the core gives one-cycle instruction strobes and the option bits are static
// How it works
// R1: counter ticks from the watchdog oscillator or the system clock divided by four.
// R2: disable option turns the clear instructions into no-operations; halt still halts.
// R3: oscillator ticks pass a fixed divide-by-256 chain first.
// R4: select bits 2..0 set prescale ratio to two to their value.
// R5: oscillator input keeps counting while halted.
// R6: oscillator disable option leaves only instruction clock as source.
// R7: instruction-clock source stops counting during halt.
// R8: bit 3 and upper nibble are plain software storage.
// R9: overflow in normal operation gives chip reset and sets timeout flag.
// R10: overflow while halted gives warm reset of program counter and stack pointer.
// R11: reset pin, clear instructions and halt clear counter and prescaler.
// R12: single-clear mode clears on every single clear instruction.
// R13: paired-clear mode clears only after both first and second instructions.
// R14: software should pick the oscillator source in noisy systems.
// R15: entering halt with oscillator source clears and restarts counting.
// R16: timeout flag cleared by power-up, clear or halt, set by timeout only.
// R17: powerdown flag cleared by power-up or clear, set by halt.
// R18: overflow when base and selected prescale stage both wrap, then recount.
`timescale 1ns/100ps
`default_nettype none
module wdtps_core
	import wdtps_pkg::*;
(
	// clock and reset
	input  wire logic                       CLOCK,
	input  wire logic                       NRST,
	// options and oscillator
	input  wire wdtps_pkg::wdtps_option_type OPTION,
	input  wire logic                       WDT_OSC,
	// core side
	input  wire wdtps_pkg::wdtps_insn_type   INSN,
	input  wire logic                       SELECT_WRITE,
	input  wire logic [7:0]                 SELECT_WDATA,
	input  wire logic                       RESUME,
	// results
	output logic [7:0]                      SELECT_RDATA,
	output wdtps_pkg::wdtps_status_type      STATUS,
	output logic                            CHIP_RESET,
	output logic                            WARM_RESET,
	output logic                            HALTED
);
	logic [1:0]                 osc_sync;
	logic                       osc_prev;
	logic [INSN_DIV_BITS-1:0]   insn_div;
	logic [BASE_STAGES-1:0]     base_cnt;
	logic [PRE_BITS-1:0]        pre_cnt;
	logic [7:0]                 select_reg;
	logic                       first_seen;
	logic                       second_seen;
	logic                       halted;
	logic                       to_flag;
	logic                       pd_flag;
	logic                       chip_reset;
	logic                       warm_reset;
	logic [INSN_DIV_BITS-1:0]   next_insn_div;
	logic [BASE_STAGES-1:0]     next_base_cnt;
	logic [PRE_BITS-1:0]        next_pre_cnt;
	logic [7:0]                 next_select_reg;
	logic                       next_first_seen;
	logic                       next_second_seen;
	logic                       next_halted;
	logic                       next_to_flag;
	logic                       next_pd_flag;
	logic                       next_chip_reset;
	logic                       next_warm_reset;
	logic                       osc_src;
	logic                       tick;
	logic                       base_wrap;
	logic                       overflow;
	logic                       clear_now;
	logic                       halt_now;
	logic                       clear_insn;
	logic [2:0]                 sel;

	// selected prescale stage has wrapped when its low bits are all ones
	function automatic logic pre_wrap(input logic [PRE_BITS-1:0] cnt, input logic [2:0] s);
		logic [PRE_BITS-1:0] mask;
		mask = PRE_BITS'((1 << s) - 1);
		return (cnt & mask) == mask;
	endfunction

	// oscillator pin is asynchronous; only the second stage is looked at
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			osc_sync <= 2'b00;
			osc_prev <= 1'b0;
		end else begin
			osc_sync <= {osc_sync[0], WDT_OSC};
			osc_prev <= osc_sync[1];
		end
	end

	always_comb begin
		osc_src    = OPTION.use_osc && OPTION.osc_enable; // see R6
		sel        = select_reg[SEL_MSB:SEL_LSB];
		// oscillator edges still count while halted; instruction clock does not
		tick = osc_src ? (osc_sync[1] && !osc_prev) // see R1, R5
			: (!halted && insn_div == INSN_LAST); // see R1, R7
		base_wrap  = base_cnt == BASE_STAGES'(BASE_DIV - 1); // see R3
		overflow   = OPTION.enable && tick && base_wrap && pre_wrap(pre_cnt, sel); // see R4, R18
		clear_insn = OPTION.paired_clear
			? ((INSN.clear_first && second_seen) || (INSN.clear_second && first_seen)) // see R13
			: INSN.clear_single; // see R12
		clear_insn = clear_insn && OPTION.enable && !halted; // see R2
		halt_now   = INSN.halt && !halted;
		clear_now  = clear_insn || (halt_now && OPTION.enable); // see R11, R15
	end

	always_comb begin
		next_insn_div    = halted ? insn_div : insn_div + INSN_DIV_BITS'(1);
		next_base_cnt    = base_cnt;
		next_pre_cnt     = pre_cnt;
		next_select_reg  = select_reg;
		next_first_seen  = first_seen;
		next_second_seen = second_seen;
		next_halted      = halted;
		next_to_flag     = to_flag;
		next_pd_flag     = pd_flag;
		next_chip_reset  = 1'b0;
		next_warm_reset  = 1'b0;
		if (SELECT_WRITE) begin
			next_select_reg = SELECT_WDATA; // see R8
		end
		if (OPTION.enable && OPTION.paired_clear && !halted) begin
			if (INSN.clear_first) begin
				next_first_seen = 1'b1;
			end
			if (INSN.clear_second) begin
				next_second_seen = 1'b1;
			end
		end
		if (OPTION.enable && tick) begin
			next_base_cnt = base_cnt + BASE_STAGES'(1);
			if (base_wrap) begin
				next_pre_cnt = pre_wrap(pre_cnt, sel) ? '0 : pre_cnt + PRE_BITS'(1);
			end
		end
		if (clear_now) begin
			next_base_cnt    = '0;
			next_pre_cnt     = '0;
			next_first_seen  = 1'b0;
			next_second_seen = 1'b0;
			if (clear_insn) begin
				next_to_flag = 1'b0; // see R16
				next_pd_flag = 1'b0; // see R17
			end
		end
		// halt after clear so the powerdown set wins over a same-cycle clear
		if (halt_now) begin
			next_halted  = 1'b1;
			next_pd_flag = 1'b1; // see R17
			next_to_flag = 1'b0; // see R16
		end
		if (RESUME && halted) begin
			next_halted = 1'b0;
		end
		// timeout sets after any clear in the same cycle, so the event is not lost
		if (overflow) begin
			next_to_flag     = 1'b1; // see R9, R16
			next_base_cnt    = '0;
			next_pre_cnt     = '0;
			next_first_seen  = 1'b0;
			next_second_seen = 1'b0;
			if (halted) begin
				next_warm_reset = 1'b1; // see R10
				next_halted     = 1'b0;
			end else begin
				next_chip_reset = 1'b1; // see R9
				next_select_reg = SELECT_RESET;
			end
		end
	end

	// reset pin clears counter and prescaler and loads the select register with SELECT_RESET
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			insn_div    <= '0;
			base_cnt    <= '0; // see R11
			pre_cnt     <= '0;
			select_reg  <= SELECT_RESET;
			first_seen  <= 1'b0;
			second_seen <= 1'b0;
			halted      <= 1'b0;
			to_flag     <= 1'b0;
			pd_flag     <= 1'b0;
			chip_reset  <= 1'b0;
			warm_reset  <= 1'b0;
		end else begin
			insn_div    <= next_insn_div;
			base_cnt    <= next_base_cnt;
			pre_cnt     <= next_pre_cnt;
			select_reg  <= next_select_reg;
			first_seen  <= next_first_seen;
			second_seen <= next_second_seen;
			halted      <= next_halted;
			to_flag     <= next_to_flag;
			pd_flag     <= next_pd_flag;
			chip_reset  <= next_chip_reset;
			warm_reset  <= next_warm_reset;
		end
	end

	assign SELECT_RDATA     = select_reg;
	assign STATUS           = '{timeout: to_flag, powerdown: pd_flag};
	assign CHIP_RESET       = chip_reset;
	assign WARM_RESET       = warm_reset;
	assign HALTED           = halted;

	a_disabled_quiet: assert property (@(posedge CLOCK) disable iff (!NRST) // see R2
		!OPTION.enable |=> !chip_reset && !warm_reset)
		else $error("reset pulse while watchdog disabled");
	a_single_clear: assert property (@(posedge CLOCK) disable iff (!NRST) // see R12
		OPTION.enable && !OPTION.paired_clear && INSN.clear_single && !halted && !overflow
		|=> base_cnt == '0 && pre_cnt == '0 && !to_flag)
		else $error("single clear did not clear counter");
	a_pair_needed: assert property (@(posedge CLOCK) disable iff (!NRST) // see R13
		OPTION.enable && OPTION.paired_clear && INSN.clear_first && !INSN.clear_second && !second_seen
		&& !halted && !INSN.halt && !overflow && (base_cnt != '0 || pre_cnt != '0)
		|=> base_cnt != '0 || pre_cnt != '0)
		else $error("first clear alone cleared counter");
	a_halt_flags: assert property (@(posedge CLOCK) disable iff (!NRST) // see R17
		INSN.halt && !halted && !overflow |=> pd_flag && halted && !to_flag)
		else $error("halt did not set powerdown");
	sequence s_chip_pulse;
		chip_reset && to_flag ##1 !chip_reset;
	endsequence
	a_overflow_normal: assert property (@(posedge CLOCK) disable iff (!NRST) // see R9
		overflow && !halted |=> s_chip_pulse)
		else $error("normal overflow lacked chip reset");
	a_overflow_halt: assert property (@(posedge CLOCK) disable iff (!NRST) // see R10
		overflow && halted |=> warm_reset && !chip_reset && to_flag)
		else $error("halted overflow lacked warm reset");
	a_insn_stopped: assert property (@(posedge CLOCK) disable iff (!NRST) // see R7
		halted && !osc_src |-> !tick)
		else $error("instruction clock ticked while halted");
	a_user_bits: assert property (@(posedge CLOCK) disable iff (!NRST) // see R8
		SELECT_WRITE && !overflow |=> select_reg == $past(SELECT_WDATA))
		else $error("select write not stored");
	a_flag_hold: assert property (@(posedge CLOCK) disable iff (!NRST) // see R16
		!to_flag && !overflow |=> !to_flag)
		else $error("timeout flag set without overflow");
endmodule
`default_nettype wire

//--- bench/wdtps_cpu_model.sv
// processor core stand-in: one-cycle watchdog instruction strobes, wake pulse, watchdog oscillator
// assumes the bench calls its tasks at a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module wdtps_cpu_model (
	// clock
	input  wire logic                 CLOCK,
	// towards the watchdog
	output wdtps_pkg::wdtps_insn_type INSN,
	output logic                      RESUME,
	output logic                      WDT_OSC
);
	import wdtps_pkg::*;
	// oscillator free-runs, halted or not; fast so time-outs stay short
	initial begin
		WDT_OSC = 1'b0;
		forever #80 WDT_OSC = ~WDT_OSC;
	end
	initial begin
		INSN = '0;
		RESUME = 1'b0;
	end
	// idle cycle after each strobe so back-to-back calls never re-drive in one step
	task automatic issue(input wdtps_insn_type i);
		INSN = i;
		@(negedge CLOCK);
		INSN = '0;
		@(negedge CLOCK);
	endtask
	task automatic pair_clear;
		issue(wdtps_insn_type'(4'h4));
		issue(wdtps_insn_type'(4'h2));
	endtask
	task automatic wake;
		RESUME = 1'b1;
		@(negedge CLOCK);
		RESUME = 1'b0;
		@(negedge CLOCK);
	endtask
endmodule
`default_nettype wire

//--- bench/watchdog_timer_with_prescaler_test.sv
// self-checking bench for the watchdog core, instruction-clock and oscillator sources
// assumes the core stand-in model drives instructions and the oscillator
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_with_prescaler_test;
	import wdtps_pkg::*;
	logic             CLOCK, NRST, SELECT_WRITE, RESUME, WDT_OSC, CHIP_RESET, WARM_RESET, HALTED;
	logic [7:0]       SELECT_WDATA, SELECT_RDATA;
	wdtps_option_type OPTION;
	wdtps_insn_type   INSN;
	wdtps_status_type STATUS;
	int               n_errors = 0, checked = 0, n, i;
	// select value beside expected time-out in system cycles
	logic [39:0]      rows [3] = '{{8'hF8, 32'h0000_0400}, {8'hA9, 32'h0000_0800}, {8'h52, 32'h0000_1000}};
	wdtps_core dut (.CLOCK(CLOCK), .NRST(NRST), .OPTION(OPTION), .WDT_OSC(WDT_OSC), .INSN(INSN),
		.SELECT_WRITE(SELECT_WRITE), .SELECT_WDATA(SELECT_WDATA), .RESUME(RESUME),
		.SELECT_RDATA(SELECT_RDATA), .STATUS(STATUS), .CHIP_RESET(CHIP_RESET), .WARM_RESET(WARM_RESET),
		.HALTED(HALTED));
	wdtps_cpu_model cpu (.CLOCK(CLOCK), .INSN(INSN), .RESUME(RESUME), .WDT_OSC(WDT_OSC));
	initial begin
		CLOCK = 1'b0;
		forever #20 CLOCK = ~CLOCK;
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic do_reset(input wdtps_option_type opt);
		OPTION = opt;
		NRST = 1'b0;
		repeat (16) @(negedge CLOCK);
		NRST = 1'b1;
		@(negedge CLOCK);
	endtask
	task automatic write_select(input logic [7:0] d);
		SELECT_WRITE = 1'b1;
		SELECT_WDATA = d;
		@(negedge CLOCK);
		SELECT_WRITE = 1'b0;
		@(negedge CLOCK);
	endtask
	// counts falling edges until the chosen reset pulse or the bound
	task automatic wait_pulse(input int bound, input logic warm, input logic must, output int cnt);
		cnt = 0;
		while (cnt < bound && (warm ? WARM_RESET : CHIP_RESET) !== 1'b1) begin
			@(negedge CLOCK);
			cnt++;
		end
		if (must && cnt == bound) begin
			n_errors++;
			$display("MISMATCH %0t reset pulse never came", $time);
			print_verdict;
		end
	endtask
	task automatic near(input int got, input int exp, input int tol, input string msg);
		check(got + tol >= exp && got <= exp + tol, 1, msg);
	endtask
	initial begin
		NRST = 1'b0;
		SELECT_WRITE = 1'b0;
		SELECT_WDATA = 8'h00;
		OPTION = '0;
		do_reset(wdtps_option_type'(4'h8));
		check(SELECT_RDATA, 8'h07, "select reset value");
		check(STATUS, 2'h0, "flags after power-up");
		for (i = 0; i < 3; i++) begin
			write_select(rows[i][39:32]);
			check(SELECT_RDATA, rows[i][39:32], "select readback");
			cpu.issue(wdtps_insn_type'(4'h8));
			wait_pulse(rows[i][31:0] + 16, 1'b0, 1'b1, n);
			near(n, rows[i][31:0] - 2, 8, "time-out length");
			@(negedge CLOCK);
			check(STATUS, 2'h2, "timeout flag set");
			check(SELECT_RDATA, 8'h07, "select reload");
		end
		$display("test prescale rows done");
		write_select(8'h00);
		cpu.issue(wdtps_insn_type'(4'h8));
		check(STATUS, 2'h0, "clear drops timeout");
		for (i = 0; i < 3; i++) begin
			wait_pulse(900, 1'b0, 1'b0, n);
			check(n, 900, "single clear holds off");
			cpu.issue(wdtps_insn_type'(4'h8));
		end
		cpu.issue(wdtps_insn_type'(4'h1));
		check({HALTED, STATUS}, 3'h5, "halt sets powerdown");
		wait_pulse(2000, 1'b1, 1'b0, n);
		check(n, 2000, "instruction clock stops in halt");
		check(CHIP_RESET, 1'b0, "no chip reset in halt");
		cpu.wake;
		check(HALTED, 1'b0, "resume leaves halt");
		$display("test single clear and halt done");
		do_reset(wdtps_option_type'(4'h9));
		write_select(8'h00);
		repeat (500) @(negedge CLOCK);
		cpu.issue(wdtps_insn_type'(4'h4));
		wait_pulse(1100, 1'b0, 1'b1, n);
		near(n, 520, 8, "first clear alone does not clear");
		write_select(8'h00);
		// late pair, so a pair that failed to clear shows as a short count
		repeat (300) @(negedge CLOCK);
		cpu.pair_clear;
		wait_pulse(1100, 1'b0, 1'b1, n);
		near(n, 1022, 8, "paired clear restarts count");
		$display("test paired clear done");
		do_reset(wdtps_option_type'(4'hE));
		write_select(8'h00);
		cpu.issue(wdtps_insn_type'(4'h8));
		repeat (1000) @(negedge CLOCK);
		cpu.issue(wdtps_insn_type'(4'h1));
		wait_pulse(2200, 1'b1, 1'b1, n);
		near(n, 1022, 8, "halt clears and recounts");
		@(negedge CLOCK);
		check(STATUS, 2'h3, "warm reset flags");
		check(SELECT_RDATA, 8'h00, "warm reset keeps select");
		$display("test oscillator halt done");
		// oscillator chosen but switched off: instruction clock, frozen in halt
		do_reset(wdtps_option_type'(4'hC));
		write_select(8'h00);
		cpu.issue(wdtps_insn_type'(4'h1));
		wait_pulse(1200, 1'b1, 1'b0, n);
		check(n, 1200, "no oscillator, halt stops count");
		$display("test oscillator off done");
		do_reset(wdtps_option_type'(4'h0));
		cpu.issue(wdtps_insn_type'(4'h1));
		check({HALTED, STATUS}, 3'h5, "halt still halts when disabled");
		cpu.wake;
		cpu.issue(wdtps_insn_type'(4'h8));
		check(STATUS, 2'h1, "disabled clear is a no-op");
		wait_pulse(1200, 1'b0, 1'b0, n);
		check(n, 1200, "disabled never resets");
		$display("test disabled done");
		print_verdict;
	end
endmodule
`default_nettype wire
